//--- src/tnsg_pkg.sv
// Behaviour
// R1: Each tone holds a 10-bit half period
// R2: Tone counter decrements every sixteen input clocks
// R3: Zero borrow toggles output, reloads period
// R4: Attenuator weights 16/8/4/2 dB, all-ones silences
// R5: Noise is fifteen-stage XOR-fed shift register
// R6: Feedback prevents all-zero lock-up
// R7: Feedback-select bit picks periodic or white
// R8: Changing feedback-select clears the noise register
// R9: Two-bit field picks four noise rates
// R10: Rates clk/512, /1024, /2048, or tone 3
// R11: Noise uses same attenuator as tones
// R12: Eight data lines, write strobe, enable, ready
// R13: Host sends two-byte period, one-byte attenuation
// R14: First byte's three-bit field picks register
// R15: Codes 0-5 tone period/atten, 6 noise, 7 atten
// R16: Attenuation byte: 1, select, four attenuation bits
// R17: Period bytes: 1+select+high four, 0+low six
// R18: System supplies continuous input clock
// R19: Ready output is open-drain, wire-OR capable
// R20: Write-strobe level marks write versus read
package tnsg_pkg;

  // ==========================================================
  // Widths
  localparam int PERIOD_W = 10;
  localparam int ATT_W = 4;
  localparam int NOISE_W = 15;
  localparam int LEVEL_W = 8;
  localparam int MIX_W = 10;

  // ==========================================================
  // Control byte layout, bit 0 of the format is data bit 7
  localparam int LEAD_BIT = 7;
  localparam int SEL_HI = 6;
  localparam int SEL_LO = 4;
  localparam int NIB_HI = 3;
  localparam int LOW6_HI = 5;
  localparam int FB_BIT = 2;
  localparam int RATE_HI = 1;

  // ==========================================================
  // Register select codes
  localparam logic [2:0] SEL_T1_PER = 3'h0;
  localparam logic [2:0] SEL_T1_ATT = 3'h1;
  localparam logic [2:0] SEL_T2_PER = 3'h2;
  localparam logic [2:0] SEL_T2_ATT = 3'h3;
  localparam logic [2:0] SEL_T3_PER = 3'h4;
  localparam logic [2:0] SEL_T3_ATT = 3'h5;
  localparam logic [2:0] SEL_NOISE_CTL = 3'h6;
  localparam logic [2:0] SEL_NOISE_ATT = 3'h7;

  // ==========================================================
  // Reset values
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 10'h000;
  localparam logic [ATT_W-1:0] ATT_RST = 4'hf;
  localparam logic [2:0] NOISE_CTL_RST = 3'h0;
  localparam logic [NOISE_W-1:0] NOISE_RST = 15'h0000;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 20;
  localparam int BUSY_NS = 80;
  localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] BUSY_CNT = 4'(BUSY_CYC);
  localparam logic [3:0] PRESCALE_MAX = 4'hf;
  localparam logic [1:0] RATE_TONE3 = 2'h3;
  localparam int RATE_DIV_W = 7;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [PERIOD_W-1:0] period;
    logic [ATT_W-1:0] atten;
  } tnsg_chan_s;

  typedef struct packed {
    logic feedbackSel;
    logic [1:0] rateSel;
  } tnsg_noise_ctl_s;

  // ==========================================================
  // Attenuation code to linear amplitude, 2 dB per step
  function automatic logic [LEVEL_W-1:0] att_level(input logic [ATT_W-1:0] att);
    logic [LEVEL_W-1:0] lvl;
    lvl = 8'h00;
    case (att)
      4'h0: lvl = 8'hff;
      4'h1: lvl = 8'hcb;
      4'h2: lvl = 8'ha1;
      4'h3: lvl = 8'h80;
      4'h4: lvl = 8'h66;
      4'h5: lvl = 8'h51;
      4'h6: lvl = 8'h40;
      4'h7: lvl = 8'h33;
      4'h8: lvl = 8'h28;
      4'h9: lvl = 8'h20;
      4'ha: lvl = 8'h1a;
      4'hb: lvl = 8'h14;
      4'hc: lvl = 8'h10;
      4'hd: lvl = 8'h0d;
      4'he: lvl = 8'h0a;
      default: lvl = 8'h00;
    endcase
    return lvl;
  endfunction

endpackage

//--- src/tnsg_tone.sv
`timescale 1ns/1ps
// ==========================================================
// One tone channel: half-period down counter and square flip-flop
module tnsg_tone (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic [tnsg_pkg::PERIOD_W-1:0] period,
  output logic [tnsg_pkg::PERIOD_W-1:0] count,
  output logic square
);

  logic [tnsg_pkg::PERIOD_W-1:0] next_count; // Counter next value
  logic next_square; // Square next value

  // Decrement on tick, borrow at zero reloads and toggles
  always_comb begin
    next_count = count;
    next_square = square;
    if (tick) begin
      if (count == '0) begin
        next_count = period; // see R3
        next_square = ~square; // see R3
      end else begin
        next_count = count - 10'h001; // see R2
      end
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count <= tnsg_pkg::PERIOD_RST;
      square <= 1'b0;
    end else begin
      count <= next_count;
      square <= next_square;
    end
  end

  // ==========================================================
  // Checks
  AST_TONE_RELOAD: assert property (@(posedge mclk) disable iff (!nrst) // see R3
    (tick && count == '0) |=> (square != $past(square) && count == $past(period)))
    else $error("tone borrow did not toggle and reload");
  AST_TONE_DEC: assert property (@(posedge mclk) disable iff (!nrst) // see R2
    (tick && count != '0) |=> (count == $past(count) - 10'h001 && square == $past(square)))
    else $error("tone counter did not step down by one");
  AST_TONE_HOLD: assert property (@(posedge mclk) disable iff (!nrst) // see R2
    !tick |=> $stable(count))
    else $error("tone counter moved without a tick");

endmodule

//--- src/tnsg_noise.sv
`timescale 1ns/1ps
// ==========================================================
// Noise source: fifteen-stage shift register with XOR feedback
module tnsg_noise (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic shift,
  input wire logic clear,
  input wire logic feedbackSel,
  output logic [tnsg_pkg::NOISE_W-1:0] lfsr,
  output logic noiseBit
);

  logic [tnsg_pkg::NOISE_W-1:0] next_lfsr; // Shift register next value
  logic feedback; // Bit entering the top stage

  // Feedback taps and shift, clear has priority
  always_comb begin
    // White uses two taps, periodic recirculates one; zero state injects a one
    feedback = (feedbackSel ? lfsr[0] : (lfsr[0] ^ lfsr[1])) ^ (lfsr == '0); // see R5, see R6, see R7
    next_lfsr = lfsr;
    if (clear) begin
      next_lfsr = tnsg_pkg::NOISE_RST; // see R8
    end else if (shift) begin
      next_lfsr = {feedback, lfsr[tnsg_pkg::NOISE_W-1:1]}; // see R5
    end
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lfsr <= tnsg_pkg::NOISE_RST;
    end else begin
      lfsr <= next_lfsr;
    end
  end

  assign noiseBit = lfsr[0];

  // ==========================================================
  // Checks
  AST_NOISE_CLEAR: assert property (@(posedge mclk) disable iff (!nrst) // see R8
    clear |=> lfsr == '0)
    else $error("noise register not cleared");
  AST_NOISE_UNLOCK: assert property (@(posedge mclk) disable iff (!nrst) // see R6
    (shift && !clear && lfsr == '0) |=> lfsr != '0)
    else $error("noise register stuck at zero");

endmodule

//--- src/tnsg_sound.sv
`timescale 1ns/1ps
// ==========================================================
// Tone and noise sound generator, byte-wide write-only port
module tnsg_sound (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] busData,
  input wire logic writeStrobeN,
  input wire logic chipEnableN,
  output logic readyOut,
  output logic readyOeN,
  output logic [2:0] toneSquare,
  output logic noiseBit,
  output logic [tnsg_pkg::LEVEL_W-1:0] chanLevel [4],
  output logic [tnsg_pkg::MIX_W-1:0] mixOut
);

  // ==========================================================
  // Bus front end
  typedef enum logic [1:0] {BUS_IDLE, BUS_BUSY, BUS_WAIT} tnsg_bus_e;

  tnsg_bus_e busState; // Access state
  tnsg_bus_e next_busState;
  logic [3:0] busyCnt; // Ready-hold counter
  logic [3:0] next_busyCnt;
  logic take; // Write byte accepted this cycle

  // A write is taken once per access, ready held low meanwhile
  always_comb begin
    next_busState = busState;
    next_busyCnt = busyCnt;
    take = 1'b0;
    case (busState)
      BUS_IDLE: begin
        // Write strobe low marks a write; reads are ignored
        if (!chipEnableN && !writeStrobeN) begin // see R12, see R20
          take = 1'b1;
          next_busyCnt = tnsg_pkg::BUSY_CNT;
          next_busState = BUS_BUSY;
        end
      end
      BUS_BUSY: begin
        next_busyCnt = busyCnt - 4'h1;
        if (busyCnt == 4'h1) begin
          next_busState = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        // Wait for the access to end before taking another
        if (chipEnableN || writeStrobeN) begin
          next_busState = BUS_IDLE;
        end
      end
      default: next_busState = BUS_IDLE;
    endcase
  end

  // Bus state registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busState <= BUS_IDLE;
      busyCnt <= 4'h0;
    end else begin
      busState <= next_busState;
      busyCnt <= next_busyCnt;
    end
  end

  // Open-drain ready: only ever pulls low
  assign readyOut = 1'b0; // see R19
  assign readyOeN = (busState != BUS_BUSY); // see R19

  // ==========================================================
  // Control registers
  tnsg_pkg::tnsg_chan_s chan [3]; // Tone settings
  tnsg_pkg::tnsg_chan_s next_chan [3];
  tnsg_pkg::tnsg_noise_ctl_s noiseCtl; // Noise setup
  tnsg_pkg::tnsg_noise_ctl_s next_noiseCtl;
  logic [tnsg_pkg::ATT_W-1:0] noiseAtt; // Noise attenuation
  logic [tnsg_pkg::ATT_W-1:0] next_noiseAtt;
  logic [2:0] latchSel; // Select of last leading byte
  logic [2:0] next_latchSel;
  logic [3:0] highNib; // High period bits waiting for second byte
  logic [3:0] next_highNib;
  logic freqPend; // Second period byte expected
  logic next_freqPend;
  logic noiseClear; // Feedback select changed
  logic [2:0] sel; // Select field of this byte
  logic [3:0] nib; // Data nibble of this byte

  // Decode a taken byte into the addressed register
  always_comb begin
    next_chan = chan;
    next_noiseCtl = noiseCtl;
    next_noiseAtt = noiseAtt;
    next_latchSel = latchSel;
    next_highNib = highNib;
    next_freqPend = freqPend;
    noiseClear = 1'b0;
    sel = busData[tnsg_pkg::SEL_HI:tnsg_pkg::SEL_LO]; // see R14
    nib = busData[tnsg_pkg::NIB_HI:0];
    if (take) begin
      if (busData[tnsg_pkg::LEAD_BIT]) begin
        next_latchSel = sel;
        next_freqPend = 1'b0;
        case (sel) // see R15
          tnsg_pkg::SEL_T1_PER, tnsg_pkg::SEL_T2_PER, tnsg_pkg::SEL_T3_PER: begin
            next_highNib = nib; // see R17, see R13
            next_freqPend = 1'b1;
          end
          tnsg_pkg::SEL_T1_ATT, tnsg_pkg::SEL_T2_ATT, tnsg_pkg::SEL_T3_ATT: begin
            next_chan[sel[2:1]].atten = nib; // see R16
          end
          tnsg_pkg::SEL_NOISE_CTL: begin
            next_noiseCtl.feedbackSel = nib[tnsg_pkg::FB_BIT]; // see R7
            next_noiseCtl.rateSel = nib[tnsg_pkg::RATE_HI:0]; // see R9
            noiseClear = (nib[tnsg_pkg::FB_BIT] != noiseCtl.feedbackSel); // see R8
          end
          default: begin
            next_noiseAtt = nib; // see R16, see R11
          end
        endcase
      end else if (freqPend) begin
        // Second byte completes the ten-bit half period
        next_chan[latchSel[2:1]].period = {highNib, busData[tnsg_pkg::LOW6_HI:0]}; // see R1, see R17
        next_freqPend = 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) begin
        chan[i].period <= tnsg_pkg::PERIOD_RST;
        chan[i].atten <= tnsg_pkg::ATT_RST;
      end
      noiseCtl <= tnsg_pkg::NOISE_CTL_RST;
      noiseAtt <= tnsg_pkg::ATT_RST;
      latchSel <= 3'h0;
      highNib <= 4'h0;
      freqPend <= 1'b0;
    end else begin
      chan <= next_chan;
      noiseCtl <= next_noiseCtl;
      noiseAtt <= next_noiseAtt;
      latchSel <= next_latchSel;
      highNib <= next_highNib;
      freqPend <= next_freqPend;
    end
  end

  // ==========================================================
  // Clock scaling
  logic [3:0] prescale; // Divide by sixteen
  logic [3:0] next_prescale;
  logic [tnsg_pkg::RATE_DIV_W-1:0] rateDiv; // Counts tone ticks for noise
  logic [tnsg_pkg::RATE_DIV_W-1:0] next_rateDiv;
  logic toneTick; // One clock in sixteen
  logic tone3Prev; // Last tone 3 level
  logic noiseShift; // Noise shift strobe

  // Prescaler and noise rate selection
  always_comb begin
    toneTick = (prescale == tnsg_pkg::PRESCALE_MAX); // see R2
    next_prescale = prescale + 4'h1;
    next_rateDiv = toneTick ? rateDiv + 7'h01 : rateDiv;
    case (noiseCtl.rateSel) // see R9, see R10
      2'h0: noiseShift = toneTick && (rateDiv[4:0] == 5'h1f);
      2'h1: noiseShift = toneTick && (rateDiv[5:0] == 6'h3f);
      2'h2: noiseShift = toneTick && (rateDiv == 7'h7f);
      default: noiseShift = toneSquare[2] && !tone3Prev;
    endcase
  end

  // Scaling registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prescale <= 4'h0;
      rateDiv <= 7'h00;
      tone3Prev <= 1'b0;
    end else begin
      prescale <= next_prescale;
      rateDiv <= next_rateDiv;
      tone3Prev <= toneSquare[2];
    end
  end

  // ==========================================================
  // Generators
  for (genvar g = 0; g < 3; g++) begin : genTone
    tnsg_tone uTone (
      .mclk(mclk),
      .nrst(nrst),
      .tick(toneTick),
      .period(chan[g].period),
      .count(),
      .square(toneSquare[g])
    );
  end

  tnsg_noise uNoise (
    .mclk(mclk),
    .nrst(nrst),
    .shift(noiseShift),
    .clear(noiseClear),
    .feedbackSel(noiseCtl.feedbackSel),
    .lfsr(),
    .noiseBit(noiseBit)
  );

  // ==========================================================
  // Attenuation and mix
  logic [tnsg_pkg::LEVEL_W-1:0] next_chanLevel [4];
  logic [tnsg_pkg::MIX_W-1:0] next_mixOut;

  // Gate each source by its attenuated amplitude, then sum
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_chanLevel[i] = toneSquare[i] ? tnsg_pkg::att_level(chan[i].atten) : 8'h00; // see R4
    end
    next_chanLevel[3] = noiseBit ? tnsg_pkg::att_level(noiseAtt) : 8'h00; // see R11
    next_mixOut = 10'(chanLevel[0]) + 10'(chanLevel[1]) + 10'(chanLevel[2]) + 10'(chanLevel[3]);
  end

  // Output registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        chanLevel[i] <= 8'h00;
      end
      mixOut <= 10'h000;
    end else begin
      chanLevel <= next_chanLevel;
      mixOut <= next_mixOut;
    end
  end

  // ==========================================================
  // Checks
  sequence seqPerFirst;
    take && busData[7] && busData[6:4] == 3'h0;
  endsequence
  sequence seqPerSecond;
    take && !busData[7] && freqPend && latchSel == 3'h0;
  endsequence

  AST_PRESCALE: assert property (@(posedge mclk) disable iff (!nrst) // see R2
    toneTick |=> !toneTick ##15 toneTick)
    else $error("tone tick not every sixteen clocks");
  AST_ATT_WRITE: assert property (@(posedge mclk) disable iff (!nrst) // see R16
    (take && busData[7] && busData[6:4] == 3'h3) |=> chan[1].atten == $past(busData[3:0]))
    else $error("tone 2 attenuation not written");
  AST_PER_WRITE: assert property (@(posedge mclk) disable iff (!nrst) // see R17
    seqPerFirst ##[1:100] seqPerSecond |=>
      chan[0].period[5:0] == $past(busData[5:0]))
    else $error("tone 1 period not assembled");
  AST_READY_HOLD: assert property (@(posedge mclk) disable iff (!nrst) // see R19
    take |=> (!readyOeN)[*4] ##1 readyOeN)
    else $error("ready not held low for the busy time");
  AST_NO_READ: assert property (@(posedge mclk) disable iff (!nrst) // see R20
    writeStrobeN |-> !take)
    else $error("read access taken as a write");
  AST_SILENT: assert property (@(posedge mclk) disable iff (!nrst) // see R4
    chan[0].atten == 4'hf |=> chanLevel[0] == 8'h00)
    else $error("all-ones attenuation not silent");
  AST_RATE0: assert property (@(posedge mclk) disable iff (!nrst) // see R10
    (noiseShift && noiseCtl.rateSel == 2'h0) |-> (prescale == 4'hf && rateDiv[4:0] == 5'h1f))
    else $error("noise shifted off the divide-by-512 beat");
  AST_FB_CLEAR: assert property (@(posedge mclk) disable iff (!nrst) // see R8
    (take && busData[7] && busData[6:4] == 3'h6 && busData[2] != noiseCtl.feedbackSel) |-> noiseClear)
    else $error("feedback change did not clear noise");

  // Register writes, pending period pairs and noise rates
  AST_T1_ATT_WRITE: assert property (@(posedge mclk) disable iff (!nrst) // see R16
    (take && busData[7] && busData[6:4] == 3'h1) |=> chan[0].atten == $past(busData[3:0]))
    else $error("tone 1 attenuation not written");
  AST_T3_ATT_WRITE: assert property (@(posedge mclk) disable iff (!nrst) // see R16
    (take && busData[7] && busData[6:4] == 3'h5) |=> chan[2].atten == $past(busData[3:0]))
    else $error("tone 3 attenuation not written");
  AST_NOISE_ATT_WRITE: assert property (@(posedge mclk) disable iff (!nrst) // see R11
    (take && busData[7] && busData[6:4] == 3'h7) |=> noiseAtt == $past(busData[3:0]))
    else $error("noise attenuation not written");
  AST_NOISE_CTL_WRITE: assert property (@(posedge mclk) disable iff (!nrst) // see R9
    (take && busData[7] && busData[6:4] == 3'h6) |=> noiseCtl == $past(busData[2:0]))
    else $error("noise setup not written");
  AST_PEND_SET: assert property (@(posedge mclk) disable iff (!nrst) // see R17
    (take && busData[7] && !busData[4] && busData[6:5] != 2'h3) |=> freqPend)
    else $error("leading period byte did not wait for its pair");
  AST_PEND_CANCEL: assert property (@(posedge mclk) disable iff (!nrst) // see R17
    (take && busData[7] && busData[4]) |=> !freqPend)
    else $error("attenuation byte left a period pair pending");
  AST_ORPHAN_LOW: assert property (@(posedge mclk) disable iff (!nrst) // see R17
    (take && !busData[7] && !freqPend) |=>
      ($stable(chan[0].period) && $stable(chan[1].period) && $stable(chan[2].period)))
    else $error("unpaired low byte changed a period");
  AST_RATE1: assert property (@(posedge mclk) disable iff (!nrst) // see R10
    (noiseShift && noiseCtl.rateSel == 2'h1) |-> (prescale == 4'hf && rateDiv[5:0] == 6'h3f))
    else $error("noise shifted off the divide-by-1024 beat");
  AST_RATE2: assert property (@(posedge mclk) disable iff (!nrst) // see R10
    (noiseShift && noiseCtl.rateSel == 2'h2) |-> (prescale == 4'hf && rateDiv == 7'h7f))
    else $error("noise shifted off the divide-by-2048 beat");
  AST_RATE3: assert property (@(posedge mclk) disable iff (!nrst) // see R10
    (noiseCtl.rateSel == 2'h3 && toneSquare[2] && !tone3Prev) |-> noiseShift)
    else $error("tone 3 rise did not shift the noise");

endmodule

//--- tb/tnsg_host.sv
`timescale 1ns/1ps
// ==========================================================
// Host processor model: byte accesses on the sound port
module tnsg_host (
  input wire logic mclk,
  input wire logic readyWire,
  output logic [7:0] busData,
  output logic writeStrobeN,
  output logic chipEnableN
);
  // Idle bus from time zero
  initial begin
    busData = 8'h00;
    writeStrobeN = 1'b1;
    chipEnableN = 1'b1;
  end

  // One access; a write is held until ready is sampled high after the busy span, a read for twelve clocks
  task automatic access(input logic [7:0] b, input logic wr, output int lowCnt);
    int n;
    lowCnt = 0;
    @(posedge mclk);
    chipEnableN <= 1'b0;
    writeStrobeN <= ~wr;
    busData <= b;
    for (n = 0; n < 12; n++) begin
      @(posedge mclk);
      // Busy samples counted, release once ready is back
      if (readyWire === 1'b0) begin
        lowCnt++;
      end else if (wr && lowCnt > 0) begin
        break;
      end
    end
    // Released data inverted so a stale byte never lingers
    chipEnableN <= 1'b1;
    writeStrobeN <= 1'b1;
    busData <= ~b;
  endtask

  // Period update as two bytes, high bits first
  task automatic period(input logic [2:0] sel, input logic [9:0] p, output int lc0, output int lc1);
    access({1'b1, sel, p[9:6]}, 1'b1, lc0);
    access({2'b00, p[5:0]}, 1'b1, lc1);
  endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the tone and noise generator
module testbench;
  logic mclk;
  logic nrst;
  logic [7:0] busData;
  logic writeStrobeN;
  logic chipEnableN;
  logic readyOut;
  logic readyOeN;
  logic readyWire;
  logic [2:0] toneSquare;
  logic noiseBit;
  logic [tnsg_pkg::LEVEL_W-1:0] chanLevel [4];
  logic [tnsg_pkg::MIX_W-1:0] mixOut;
  int errors;
  int n_compared;
  int lc0;
  int lc1;
  int gap;
  int i;
  int r;
  // Attenuation byte, channel and the amplitude it should give
  typedef struct packed {
    logic [7:0] b;
    logic [1:0] ch;
    logic [7:0] lvl;
  } tnsg_row_s;
  tnsg_row_s rows [10] = '{
    '{8'h90, 2'h0, 8'hff}, '{8'h91, 2'h0, 8'hcb}, '{8'h92, 2'h0, 8'ha1}, '{8'h94, 2'h0, 8'h66},
    '{8'h98, 2'h0, 8'h28}, '{8'h9f, 2'h0, 8'h00}, '{8'hb3, 2'h1, 8'h80}, '{8'hd5, 2'h2, 8'h51},
    '{8'hf7, 2'h3, 8'h33}, '{8'hfe, 2'h3, 8'h0a}};

  // ==========================================================
  // Clock, design, host and shared ready line
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  tnsg_sound dut_u (
    .mclk(mclk),
    .nrst(nrst),
    .busData(busData),
    .writeStrobeN(writeStrobeN),
    .chipEnableN(chipEnableN),
    .readyOut(readyOut),
    .readyOeN(readyOeN),
    .toneSquare(toneSquare),
    .noiseBit(noiseBit),
    .chanLevel(chanLevel),
    .mixOut(mixOut)
  );

  tnsg_host host_u (
    .mclk(mclk),
    .readyWire(readyWire),
    .busData(busData),
    .writeStrobeN(writeStrobeN),
    .chipEnableN(chipEnableN)
  );

  // Pull-up on the wired ready line
  assign readyWire = readyOeN ? 1'b1 : readyOut;

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Square of a tone, or the noise bit for index 3
  function automatic logic sig(input int idx);
    return (idx < 3) ? toneSquare[idx] : noiseBit;
  endfunction

  // Counts cycles while the watched output stays at a level
  task automatic run(input int idx, input logic lvl, inout int g);
    while (sig(idx) === lvl && g < 40000) begin
      @(negedge mclk);
      g++;
    end
    // A stuck output counts as a mismatch
    if (g >= 40000) begin
      errors++;
    end
  endtask

  // Length of the next full high phase, or of a whole period
  task automatic measure(input int idx, input logic whole, output int g);
    int j;
    j = 0;
    g = 0;
    run(idx, 1'b1, j);
    run(idx, 1'b0, j);
    run(idx, 1'b1, g);
    if (whole) begin
      run(idx, 1'b0, g);
    end
  endtask

  // Single write; ready must be held low for the busy span
  task automatic wr(input logic [7:0] b);
    host_u.access(b, 1'b1, lc0);
    check(lc0, 4);
  endtask

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    errors = 0;
    n_compared = 0;
    nrst = 1'b0;
    repeat (10) @(negedge mclk);
    // Quiet outputs while held in reset
    check(readyOeN, 1);
    check(toneSquare, 0);
    check(mixOut, 0);
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    // Period zero toggles every tick, channel silent
    measure(0, 1'b0, gap);
    check(gap, 16);
    check(chanLevel[0], 0);
    check(readyOut, 0);
    // Periodic noise stepped by tone 3
    wr(8'he7);
    // Ordinary attenuation cases
    for (i = 0; i < 10; i++) begin
      wr(rows[i].b);
      gap = 0;
      run(rows[i].ch, 1'b1, gap);
      run(rows[i].ch, 1'b0, gap);
      repeat (2) @(negedge mclk);
      check(chanLevel[rows[i].ch], rows[i].lvl);
    end
    // One step per tone 3 rise, fifteen steps per cycle
    measure(3, 1'b0, gap);
    check(gap, 32);
    measure(3, 1'b1, gap);
    check(gap, 480);
    // Feedback change while the bit is high empties the register
    gap = 0;
    run(3, 1'b1, gap);
    run(3, 1'b0, gap);
    wr(8'he3);
    @(negedge mclk);
    check(noiseBit, 0);
    wr(8'he7);
    // Divided shift rates
    for (r = 0; r < 3; r++) begin
      wr(8'he4 | 8'(r));
      measure(3, 1'b0, gap);
      check(gap, 512 << r);
    end
    // Two-byte period updates
    host_u.period(3'h0, 10'h003, lc0, lc1);
    check(lc1, 4);
    measure(0, 1'b0, gap);
    check(gap, 64);
    host_u.period(3'h0, 10'h041, lc0, lc1);
    measure(0, 1'b0, gap);
    check(gap, 1056);
    // Pending pair cancelled by another leading byte
    wr(8'h85);
    wr(8'h90);
    wr(8'h02);
    measure(0, 1'b0, gap);
    check(gap, 1056);
    host_u.period(3'h2, 10'h007, lc0, lc1);
    measure(1, 1'b0, gap);
    check(gap, 128);
    // Read access leaves the port idle
    host_u.access(8'h80, 1'b0, lc0);
    check(lc0, 0);
    // Second reset in mid-run
    nrst <= 1'b0;
    @(negedge mclk);
    check(readyOeN, 1);
    check(toneSquare, 0);
    check(noiseBit, 0);
    @(posedge mclk);
    nrst <= 1'b1;
    // Registers back at reset values: period zero, channel silent
    measure(0, 1'b0, gap);
    check(gap, 16);
    check(chanLevel[0], 0);
    close_out();
  end
endmodule
